// >>> core/ccg_cal.sv
`include "ccg_defines.svh"
`default_nettype none

module ccg_cal (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Reference clock pins
	input  wire logic [3:0]            ref_clk_pins,
	// Divided main clock tick
	input  wire logic                  main_div_tick,
	// Run request
	input  wire logic                  start,
	input  wire ccg_pkg::ccg_cal_req_s req,
	// Run result
	output var  ccg_pkg::ccg_cal_res_s res
);

	ccg_pkg::ccg_cal_state_e state_q;
	logic [3:0]              sync1_q;
	logic [3:0]              sync2_q;
	logic                    last_q;
	logic [1:0]              sel_q;
	logic [15:0]             remain_q;
	logic [31:0]             count_q;
	logic                    done_q;
	logic                    ref_edge;

	assign res.busy  = (state_q != ccg_pkg::CAL_IDLE);
	assign res.done  = done_q;
	assign res.count = count_q;

	// ----------------------------------------
	// Reference edge detection
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= ref_clk_pins;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_q <= 1'b0;
		end else if (state_q == ccg_pkg::CAL_IDLE) begin
			last_q <= sync2_q[req.sel];
		end else begin
			last_q <= sync2_q[sel_q];
		end
	end

	assign ref_edge = sync2_q[sel_q] & ~last_q;

	// ----------------------------------------
	// Run sequence
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ccg_pkg::CAL_IDLE;
			sel_q   <= 2'h0;
		end else begin
			unique case (state_q)
				ccg_pkg::CAL_IDLE: begin
					if (start) begin
						state_q <= ccg_pkg::CAL_WAIT;
						sel_q   <= req.sel;
					end
				end
				ccg_pkg::CAL_WAIT: begin
					if (ref_edge) begin
						state_q <= ccg_pkg::CAL_RUN;
					end
				end
				ccg_pkg::CAL_RUN: begin
					if (ref_edge && remain_q <= 16'h0001) begin
						state_q <= ccg_pkg::CAL_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remain_q <= 16'h0000;
		end else if (state_q == ccg_pkg::CAL_IDLE && start) begin
			remain_q <= (req.window == 16'h0000) ? 16'h0001 : req.window;
		end else if (state_q == ccg_pkg::CAL_RUN && ref_edge && remain_q > 16'h0001) begin
			remain_q <= remain_q - 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 32'h00000000;
		end else if (state_q == ccg_pkg::CAL_IDLE && start) begin
			count_q <= 32'h00000000;
		end else if (state_q == ccg_pkg::CAL_RUN && main_div_tick) begin
			count_q <= count_q + 32'h00000001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (state_q == ccg_pkg::CAL_RUN) && ref_edge && (remain_q <= 16'h0001);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_start_clears;
		state_q == ccg_pkg::CAL_IDLE && start |=> count_q == 32'h00000000 && res.busy;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("count not cleared on start");

	property p_result_stable;
		state_q == ccg_pkg::CAL_IDLE && !start |=> $stable(count_q);
	endproperty
	a_result_stable: assert property (p_result_stable) else $error("result moved while idle");

	property p_count_inc;
		state_q == ccg_pkg::CAL_RUN && main_div_tick |=> count_q == $past(count_q) + 32'h00000001;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("count missed a tick");

	property p_window_dec;
		state_q == ccg_pkg::CAL_RUN && ref_edge && remain_q > 16'h0001
			|=> remain_q == $past(remain_q) - 16'h0001 && res.busy;
	endproperty
	a_window_dec: assert property (p_window_dec) else $error("window not decremented");

	property p_run_end;
		state_q == ccg_pkg::CAL_RUN && ref_edge && remain_q == 16'h0001
			|=> done_q && !res.busy ##1 !done_q;
	endproperty
	a_run_end: assert property (p_run_end) else $error("run did not end at one");

	property p_edge_synced;
		state_q == ccg_pkg::CAL_RUN && ref_edge |-> $past(ref_clk_pins[sel_q], 2);
	endproperty
	a_edge_synced: assert property (p_edge_synced) else $error("edge not from sync chain");

endmodule : ccg_cal

`default_nettype wire

// >>> core/ccg_defines.svh
`ifndef CCG_DEFINES_SVH
`define CCG_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define CCG_IDX_CAL_CTRL    32'h50001B60
`define CCG_IDX_CAL_WINDOW  32'h50001B62
`define CCG_IDX_CAL_RES_LO  32'h50001B64
`define CCG_IDX_CAL_RES_HI  32'h50001B66
`define CCG_IDX_INT_STATUS  32'h50001B68
`define CCG_IDX_INT_MASK    32'h50001B6A
`define CCG_IDX_PER_CLK     32'h50001C04
`define CCG_IDX_PCM_DIV     32'h50001C40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCG_CTRL_START      2
`define CCG_CTRL_SEL_HI     1
`define CCG_CTRL_SEL_LO     0
`define CCG_PER_ADC_SRC     11
`define CCG_PER_KBS_SRC     10
`define CCG_PER_I2C_SRC     9
`define CCG_PER_SPI_SRC     8
`define CCG_PER_KBS_GATE    5
`define CCG_PER_IR_GATE     4
`define CCG_PER_QUAD_GATE   3
`define CCG_PER_I2C_GATE    2
`define CCG_PER_SPI_GATE    1
`define CCG_PER_UART_GATE   0
`define CCG_PCM_SRC         13
`define CCG_PCM_EN          12
`define CCG_PCM_DIV_HI      11
`define CCG_INT_CAL_DONE    0

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define CCG_RST_REG         16'h0000
`define CCG_PER_WMASK       16'h0F3F
`define CCG_PCM_WMASK       16'h3FFF
`define CCG_INT_WMASK       16'h0001

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCG_MAIN_DIV_RATIO  8'h04

`endif

// >>> core/ccg_pkg.sv
`default_nettype none

package ccg_pkg;

	// ----------------------------------------
	// Calibration types
	// ----------------------------------------
	typedef enum {CAL_IDLE, CAL_WAIT, CAL_RUN} ccg_cal_state_e;

	typedef struct packed {
		logic [1:0]  sel;
		logic [15:0] window;
	} ccg_cal_req_s;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [31:0] count;
	} ccg_cal_res_s;

	// ----------------------------------------
	// Peripheral clock ticks
	// ----------------------------------------
	typedef struct packed {
		logic converter;
		logic key_scanner;
		logic infrared;
		logic quad_decoder;
		logic i2c;
		logic spi;
		logic uart;
	} ccg_per_ticks_s;

endpackage : ccg_pkg

`default_nettype wire

// >>> core/ccg_placeholder_none.sv
`default_nettype none
`default_nettype wire

// >>> core/ccg_top.sv
`include "ccg_defines.svh"
`default_nettype none

// Function
// - Writing one to the start bit begins a run, and the bit reads zero again once the result is valid.
// - The two-bit source field picks the calibrated clock: 32 kHz RC, 16 MHz RC, 32 kHz crystal, 11.7 kHz RC.
// - The 16-bit window count is decremented down to one, one step per reference period.
// - Divided main clock cycles in the window are counted, the low half readable in one register.
// - The upper half of that count is readable in a second register, forming a 32-bit result.
// - Each source select bit routes the undivided main clock when one and the divided one when zero.
// - Gate bits 5 to 0 switch the key scanner, infrared, quadrature, I2C, SPI and UART clocks, all off at reset.
// - The voice-port clock comes from a 12-bit divider when its gate bit is set, divider written first or together.

module ccg_top (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Reference clock pins: 32k RC, 16M RC, 32k crystal, low rate RC
	input  wire logic [3:0]              ref_clk_pins,
	// Interrupt
	output logic                         irq,
	// Peripheral clock ticks and voice-port clock
	output ccg_pkg::ccg_per_ticks_s      per_ticks,
	output logic                         voice_port_clk
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic                  pready_q;
	logic [15:0]           prdata_q;
	logic                  pslverr_q;
	logic [1:0]            ctrl_sel_q;
	logic [15:0]           window_q;
	logic [15:0]           per_q;
	logic [15:0]           pcm_q;
	logic [15:0]           int_status_q;
	logic [15:0]           int_mask_q;
	logic                  irq_q;
	logic                  start_q;
	logic [7:0]            main_div_cnt_q;
	logic                  divided_main_clock;
	ccg_pkg::ccg_per_ticks_s ticks_q;
	logic [11:0]           pcm_cnt_q;
	logic                  pcm_clk_q;
	logic                  pcm_tick;
	logic                  access;
	logic                  take;
	logic                  wr;
	logic                  mapped;
	logic [15:0]           rdata;
	logic [15:0]           int_set;
	logic [15:0]           int_clr;
	ccg_pkg::ccg_cal_req_s cal_req;
	ccg_pkg::ccg_cal_res_s cal_res;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
		hit = (addr[31:2] == idx[29:0]) && (addr[1:0] == 2'h0);
	endfunction : hit

	function automatic logic src_tick(input logic undivided, input logic divided);
		src_tick = undivided | divided;
	endfunction : src_tick

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign access = psel & penable;
	assign take   = access & pready_q;
	assign wr     = take & pwrite;

	assign mapped = hit(paddr, `CCG_IDX_CAL_CTRL)   | hit(paddr, `CCG_IDX_CAL_WINDOW) |
	                hit(paddr, `CCG_IDX_CAL_RES_LO) | hit(paddr, `CCG_IDX_CAL_RES_HI) |
	                hit(paddr, `CCG_IDX_INT_STATUS) | hit(paddr, `CCG_IDX_INT_MASK)   |
	                hit(paddr, `CCG_IDX_PER_CLK)    | hit(paddr, `CCG_IDX_PCM_DIV);

	always_comb begin
		rdata = 16'h0000;
		if (hit(paddr, `CCG_IDX_CAL_CTRL)) begin
			rdata[`CCG_CTRL_START] = cal_res.busy | start_q;
			rdata[`CCG_CTRL_SEL_HI:`CCG_CTRL_SEL_LO] = ctrl_sel_q;
		end else if (hit(paddr, `CCG_IDX_CAL_WINDOW)) begin
			rdata = window_q;
		end else if (hit(paddr, `CCG_IDX_CAL_RES_LO)) begin
			rdata = cal_res.count[15:0];
		end else if (hit(paddr, `CCG_IDX_CAL_RES_HI)) begin
			rdata = cal_res.count[31:16];
		end else if (hit(paddr, `CCG_IDX_INT_STATUS)) begin
			rdata = int_status_q;
		end else if (hit(paddr, `CCG_IDX_INT_MASK)) begin
			rdata = int_mask_q;
		end else if (hit(paddr, `CCG_IDX_PER_CLK)) begin
			rdata = per_q;
		end else if (hit(paddr, `CCG_IDX_PCM_DIV)) begin
			rdata = pcm_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= access & ~pready_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 16'h0000;
			pslverr_q <= 1'b0;
		end else if (access && !pready_q) begin
			prdata_q  <= pwrite ? 16'h0000 : rdata;
			pslverr_q <= ~mapped;
		end else if (!access) begin
			prdata_q  <= 16'h0000;
			pslverr_q <= 1'b0;
		end
	end

	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign prdata  = {16'h0000, prdata_q};

	// ----------------------------------------
	// Calibration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_sel_q <= 2'h0;
		end else if (wr && hit(paddr, `CCG_IDX_CAL_CTRL)) begin
			ctrl_sel_q <= pwdata[`CCG_CTRL_SEL_HI:`CCG_CTRL_SEL_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window_q <= `CCG_RST_REG;
		end else if (wr && hit(paddr, `CCG_IDX_CAL_WINDOW)) begin
			window_q <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 1'b0;
		end else begin
			start_q <= wr && hit(paddr, `CCG_IDX_CAL_CTRL) && pwdata[`CCG_CTRL_START] &&
			           !cal_res.busy && !start_q;
		end
	end

	assign cal_req.sel    = ctrl_sel_q;
	assign cal_req.window = window_q;

	ccg_cal i_ccg_cal (
		.pclk          (pclk),
		.presetn       (presetn),
		.ref_clk_pins  (ref_clk_pins),
		.main_div_tick (divided_main_clock),
		.start         (start_q),
		.req           (cal_req),
		.res           (cal_res)
	);

	// ----------------------------------------
	// Interrupt
	// ----------------------------------------
	assign int_set = {15'h0000, cal_res.done};
	assign int_clr = (wr && hit(paddr, `CCG_IDX_INT_STATUS)) ?
	                 (pwdata[15:0] & `CCG_INT_WMASK) : 16'h0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status_q <= `CCG_RST_REG;
		end else begin
			int_status_q <= (int_status_q & ~int_clr) | int_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask_q <= `CCG_RST_REG;
		end else if (wr && hit(paddr, `CCG_IDX_INT_MASK)) begin
			int_mask_q <= pwdata[15:0] & `CCG_INT_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(int_status_q & int_mask_q);
		end
	end

	assign irq = irq_q;

	// ----------------------------------------
	// Divided main clock
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_div_cnt_q <= 8'h00;
		end else if (divided_main_clock) begin
			main_div_cnt_q <= 8'h00;
		end else begin
			main_div_cnt_q <= main_div_cnt_q + 8'h01;
		end
	end

	assign divided_main_clock = (main_div_cnt_q == (`CCG_MAIN_DIV_RATIO - 8'h01));

	// ----------------------------------------
	// Peripheral clocks
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_q <= `CCG_RST_REG;
		end else if (wr && hit(paddr, `CCG_IDX_PER_CLK)) begin
			per_q <= pwdata[15:0] & `CCG_PER_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ticks_q <= '0;
		end else begin
			ticks_q.converter    <= src_tick(per_q[`CCG_PER_ADC_SRC], divided_main_clock);
			ticks_q.key_scanner  <= per_q[`CCG_PER_KBS_GATE] &
			                        src_tick(per_q[`CCG_PER_KBS_SRC], divided_main_clock);
			ticks_q.infrared     <= per_q[`CCG_PER_IR_GATE] & divided_main_clock;
			ticks_q.quad_decoder <= per_q[`CCG_PER_QUAD_GATE] & divided_main_clock;
			ticks_q.i2c          <= per_q[`CCG_PER_I2C_GATE] &
			                        src_tick(per_q[`CCG_PER_I2C_SRC], divided_main_clock);
			ticks_q.spi          <= per_q[`CCG_PER_SPI_GATE] &
			                        src_tick(per_q[`CCG_PER_SPI_SRC], divided_main_clock);
			ticks_q.uart         <= per_q[`CCG_PER_UART_GATE] & divided_main_clock;
		end
	end

	assign per_ticks = ticks_q;

	// ----------------------------------------
	// Voice-port clock
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcm_q <= `CCG_RST_REG;
		end else if (wr && hit(paddr, `CCG_IDX_PCM_DIV)) begin
			pcm_q <= pwdata[15:0] & `CCG_PCM_WMASK;
		end
	end

	assign pcm_tick = src_tick(pcm_q[`CCG_PCM_SRC], divided_main_clock);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcm_cnt_q <= 12'h000;
			pcm_clk_q <= 1'b0;
		end else if (!pcm_q[`CCG_PCM_EN]) begin
			pcm_cnt_q <= 12'h000;
			pcm_clk_q <= 1'b0;
		end else if (pcm_tick && pcm_q[`CCG_PCM_DIV_HI:0] != 12'h000) begin
			if (pcm_cnt_q + 12'h001 >= pcm_q[`CCG_PCM_DIV_HI:0]) begin
				pcm_cnt_q <= 12'h000;
				pcm_clk_q <= ~pcm_clk_q;
			end else begin
				pcm_cnt_q <= pcm_cnt_q + 12'h001;
			end
		end
	end

	assign voice_port_clk = pcm_clk_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_start_run;
		wr && hit(paddr, `CCG_IDX_CAL_CTRL) && pwdata[`CCG_CTRL_START] && !cal_res.busy && !start_q
			|=> start_q ##1 cal_res.busy;
	endproperty
	a_start_run: assert property (p_start_run) else $error("start write did not begin a run");

	property p_sel_write;
		wr && hit(paddr, `CCG_IDX_CAL_CTRL) |=> ctrl_sel_q == $past(pwdata[1:0]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("source select not stored");

	property p_res_high;
		access && !pready_q && !pwrite && hit(paddr, `CCG_IDX_CAL_RES_HI)
			|=> prdata[15:0] == $past(cal_res.count[31:16]) && pready;
	endproperty
	a_res_high: assert property (p_res_high) else $error("upper result half wrong");

	property p_res_low;
		access && !pready_q && !pwrite && hit(paddr, `CCG_IDX_CAL_RES_LO)
			|=> prdata[15:0] == $past(cal_res.count[15:0]);
	endproperty
	a_res_low: assert property (p_res_low) else $error("lower result half wrong");

	property p_undivided;
		per_q[`CCG_PER_SPI_SRC] && per_q[`CCG_PER_SPI_GATE] |=> per_ticks.spi;
	endproperty
	a_undivided: assert property (p_undivided) else $error("undivided source not routed");

	property p_gate_off;
		!per_q[`CCG_PER_KBS_GATE] && !per_q[`CCG_PER_UART_GATE]
			|=> !per_ticks.key_scanner && !per_ticks.uart;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("gated clock ticked");

	property p_pcm_off;
		!pcm_q[`CCG_PCM_EN] |=> !voice_port_clk;
	endproperty
	a_pcm_off: assert property (p_pcm_off) else $error("voice clock ran while off");

	property p_pcm_toggle;
		pcm_q[`CCG_PCM_EN] && pcm_tick && pcm_q[11:0] != 12'h000 &&
		(pcm_cnt_q + 12'h001 >= pcm_q[11:0]) |=> voice_port_clk != $past(voice_port_clk);
	endproperty
	a_pcm_toggle: assert property (p_pcm_toggle) else $error("voice clock missed toggle");

	property p_irq;
		(int_status_q & int_mask_q) != 16'h0000 |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule : ccg_top

`default_nettype wire

// >>> tb/ccg_top_tb_top.sv
`include "ccg_defines.svh"
`default_nettype none

module ccg_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ----
	// Bench signals
	// ----
	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic [31:0]            paddr = 32'h0;
	logic [31:0]            pwdata = 32'h0;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic [3:0]             ref_clk_pins = 4'h0;
	logic                   irq;
	ccg_pkg::ccg_per_ticks_s per_ticks;
	logic                   voice_port_clk;
	logic [6:0]             tk;
	logic [31:0]            rdv;
	logic [31:0]            exp_q[$];
	logic                   ck_q[$];
	logic                   er_q[$];
	int                     num_errors = 0;
	int                     check_count = 0;
	int                     seed = 59;
	int                     rcnt[4] = '{0, 0, 0, 0};
	localparam int SRC[7] = '{11, 10, -1, -1, 9, 8, -1};
	localparam int GATE[7] = '{-1, 5, 4, 3, 2, 1, 0};
	localparam logic [31:0] IDX[8] = '{`CCG_IDX_CAL_CTRL, `CCG_IDX_CAL_WINDOW,
		`CCG_IDX_CAL_RES_LO, `CCG_IDX_CAL_RES_HI, `CCG_IDX_INT_STATUS,
		`CCG_IDX_INT_MASK, `CCG_IDX_PER_CLK, `CCG_IDX_PCM_DIV};
	localparam logic [15:0] VTAB[4] = '{16'h3001, 16'h3003, 16'h1001, 16'h2001};

	assign tk = per_ticks;

	always #5 pclk = ~pclk;

	// Reference clocks: half periods of 20, 24, 28 and 32 cycles
	always @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			rcnt[i] <= (rcnt[i] == 19 + 4 * i) ? 0 : rcnt[i] + 1;
			if (rcnt[i] == 19 + 4 * i) ref_clk_pins[i] <= ~ref_clk_pins[i];
		end
	end

	ccg_top i_ccg_top (
		.pclk           (pclk),
		.presetn        (presetn),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.prdata         (prdata),
		.pready         (pready),
		.pslverr        (pslverr),
		.ref_clk_pins   (ref_clk_pins),
		.irq            (irq),
		.per_ticks      (per_ticks),
		.voice_port_clk (voice_port_clk)
	);

	// ----
	// Checking
	// ----
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] seen);
		check_count++;
		if (seen !== ex) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, ex, seen);
		end
	endtask : cmp

	// Takes the oldest note whenever a transfer completes
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			cmp("pslverr", {31'h0, er_q[0]}, {31'h0, pslverr});
			if (ck_q[0]) cmp("prdata", exp_q[0], prdata);
			void'(exp_q.pop_front());
			void'(ck_q.pop_front());
			void'(er_q.pop_front());
		end
	end

	task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
		input logic ck, input logic [31:0] ex, input logic er, output logic [31:0] rd);
		int n;
		exp_q.push_back(ex);
		ck_q.push_back(ck);
		er_q.push_back(er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= idx << 2;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			num_errors++;
			finish_test();
		end
	endtask : apb

	task automatic wr(input logic [31:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 1'b0, 32'h0, 1'b0, rdv);
	endtask : wr

	task automatic rc(input logic [31:0] idx, input logic [31:0] ex);
		apb(1'b0, idx, 32'h0, 1'b1, ex, 1'b0, rdv);
	endtask : rc

	function automatic int exp_tk(input logic [15:0] v, input int k);
		if (GATE[k] >= 0 && !v[GATE[k]]) return 0;
		if (SRC[k] >= 0 && v[SRC[k]]) return 8;
		return 2;
	endfunction : exp_tk

	task automatic cal(input logic [1:0] sel, input logic [15:0] win, input logic msk);
		logic [31:0] ex;
		int i;
		ex = (win == 16'h0 ? 32'h1 : {16'h0, win}) * (32'hA + 2 * sel);
		wr(`CCG_IDX_INT_MASK, {31'h0, msk});
		wr(`CCG_IDX_CAL_WINDOW, {16'h0, win});
		wr(`CCG_IDX_CAL_CTRL, {29'h0, 1'b1, sel});
		rc(`CCG_IDX_CAL_CTRL, {29'h0, 1'b1, sel});
		for (i = 0; i < 1000; i++) begin
			apb(1'b0, `CCG_IDX_CAL_CTRL, 32'h0, 1'b0, 32'h0, 1'b0, rdv);
			if (rdv[2] === 1'b0) break;
		end
		if (i == 1000) begin
			num_errors++;
			finish_test();
		end
		rc(`CCG_IDX_CAL_CTRL, {30'h0, sel});
		rc(`CCG_IDX_CAL_RES_LO, {16'h0, ex[15:0]});
		rc(`CCG_IDX_CAL_RES_HI, {16'h0, ex[31:16]});
		rc(`CCG_IDX_CAL_RES_LO, {16'h0, ex[15:0]});
		rc(`CCG_IDX_INT_STATUS, 32'h1);
		cmp("irq", {31'h0, msk}, {31'h0, irq});
		wr(`CCG_IDX_INT_STATUS, 32'h1);
		rc(`CCG_IDX_INT_STATUS, 32'h0);
		cmp("irq", 32'h0, {31'h0, irq});
	endtask : cal

	initial begin
		logic [15:0] v;
		int c[7];
		int r;
		int e;
		logic pv;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rc(IDX[i], 32'h0);
		apb(1'b0, 32'h50001B70, 32'h0, 1'b1, 32'h0, 1'b1, rdv);
		apb(1'b1, 32'h50001B70, $random(seed), 1'b0, 32'h0, 1'b1, rdv);
		cal(2'h0, 16'h3, 1'b0);
		cal(2'h1, 16'h1, 1'b1);
		cal(2'h2, 16'h0, 1'b0);
		cal(2'h3, 16'h2, 1'b1);
		for (int j = 0; j < 5; j++) begin
			v = (j == 0) ? 16'h0F3F : (j == 1) ? 16'h0 : 16'($random(seed));
			wr(`CCG_IDX_PER_CLK, {16'h0, v});
			rc(`CCG_IDX_PER_CLK, {16'h0, v & `CCG_PER_WMASK});
			repeat (4) @(posedge pclk);
			for (int k = 0; k < 7; k++) c[k] = 0;
			repeat (8) begin
				@(posedge pclk);
				for (int k = 0; k < 7; k++) if (tk[6 - k] === 1'b1) c[k]++;
			end
			for (int k = 0; k < 7; k++) cmp("per_ticks", exp_tk(v, k), c[k]);
		end
		for (int j = 0; j < 4; j++) begin
			v = VTAB[j];
			e = v[12] ? 48 / (2 * v[11:0] * (v[13] ? 1 : 4)) : 0;
			wr(`CCG_IDX_PCM_DIV, {16'h0, v});
			rc(`CCG_IDX_PCM_DIV, {16'h0, v & `CCG_PCM_WMASK});
			repeat (16) @(posedge pclk);
			r = 0;
			pv = voice_port_clk;
			repeat (48) begin
				@(posedge pclk);
				if (voice_port_clk === 1'b1 && pv === 1'b0) r++;
				pv = voice_port_clk;
			end
			cmp("voice_port_clk rises", e, r);
		end
		finish_test();
	end
endmodule : ccg_top_tb_top

`default_nettype wire
